// [bench/mbcmd_asserts.sv]
// checker on the master-to-meter byte link
// assumes the master sends each frame back to back, one byte per cycle
`timescale 1ns/1ps
module mbcmd_asserts (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] m2s_data,
    input wire logic m2s_valid,
    input wire logic [7:0] s2m_data,
    input wire logic s2m_valid
);
    // ======================================================
    // byte position, length and running sum
    logic [3:0] idx_q;
    logic [7:0] len_q;
    logic [7:0] sum_q;
    always_ff @(posedge clk) begin
        if (!rstn || !m2s_valid) begin
            idx_q <= 4'h0;
            sum_q <= 8'h00;
        end else begin
            idx_q <= idx_q + 4'h1;
            sum_q <= (idx_q >= 4'h4) ? sum_q + m2s_data : sum_q;
        end
        len_q <= (m2s_valid && idx_q == 4'h1) ? m2s_data : len_q;
    end
    // ======================================================
    // properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_open;
        m2s_data == 8'h68 ##1 (m2s_data == 8'h07 || m2s_data == 8'h08)
            ##1 m2s_data == $past(m2s_data) ##1 m2s_data == 8'h68;
    endsequence
    sequence s_close;
        m2s_data == sum_q ##1 m2s_data == 8'h16 ##1 !m2s_valid;
    endsequence
    chk_frame_open: assert property (m2s_valid && idx_q == 4'h0 |-> s_open)
        else $error("frame head wrong");
    chk_ctl_form: assert property (m2s_valid && idx_q == 4'h4 |-> (m2s_data & 8'hdf) == 8'h53)
        else $error("control byte wrong");
    chk_ci_value: assert property (m2s_valid && idx_q == 4'h6 |-> m2s_data == 8'h51)
        else $error("ci byte wrong");
    chk_dif_value: assert property (m2s_valid && idx_q == 4'h7 |-> m2s_data == {7'h0, len_q[3]})
        else $error("dif byte wrong");
    chk_vif_chain: assert property (m2s_valid && idx_q == 4'h8 |-> m2s_data == 8'hff
        ##1 m2s_data == (len_q[3] ? 8'hf9 : 8'h98) ##1 m2s_data == (len_q[3] ? 8'h08 : 8'h07))
        else $error("vif chain wrong");
    chk_sum_stop: assert property (m2s_valid && idx_q == len_q[3:0] + 4'h4 |-> s_close)
        else $error("checksum or stop wrong");
    chk_ack_value: assert property (s2m_valid |-> s2m_data == 8'he5)
        else $error("ack byte wrong");
    chk_ack_after_stop: assert property (s2m_valid |-> $past(m2s_data) == 8'h16)
        else $error("ack not after stop");
endmodule

// [bench/mbcmd_tb.sv]
// bench: master and meter joined, plus a second meter fed raw frames
// assumes one 200 MHz clock; inputs change on the falling edge
`timescale 1ns/1ps
module mbcmd_tb;
    // ======================================================
    // signals and ends
    logic clk = 1'b0, rstn = 1'b0, req = 1'b0, req_button = 1'b0, req_value = 1'b0;
    logic resettable = 1'b1, perm_allowed = 1'b1, pfail_event = 1'b0, eben_a = 1'b1, eben_b = 1'b1;
    logic [7:0] req_addr = 8'h00, own_addr = 8'h20;
    logic busy, ack_seen, ben_a, ben_b, done_a, done_b, err_a, err_b;
    logic [15:0] pfail_a, pfail_b, exp_pa = 16'h0, exp_pb = 16'h0;
    logic [19:0] exp_q[$];
    logic [11:0] bad[9] = '{12'h201, 12'h480, 12'h440, 12'h401, 12'h601, 12'h701, 12'h801,
        12'hb01, 12'hc01};
    int n_errors = 0, cmp_count = 0, seed = 85466;
    mbcmd_if link_a();
    mbcmd_if link_b();
    mbcmd_master mbcmd_master_inst (.clk(clk), .rstn(rstn), .link(link_a), .req(req),
        .req_button(req_button), .req_addr(req_addr), .req_value(req_value), .busy(busy),
        .ack_seen(ack_seen));
    mbcmd_meter mbcmd_meter_inst (.clk(clk), .rstn(rstn), .link(link_a), .own_addr(own_addr),
        .resettable(resettable), .perm_allowed(perm_allowed), .pfail_event(pfail_event),
        .pfail_count(pfail_a), .button_reset_en(ben_a), .frame_done(done_a), .frame_error(err_a));
    mbcmd_meter mbcmd_meter_inst_b (.clk(clk), .rstn(rstn), .link(link_b), .own_addr(own_addr),
        .resettable(resettable), .perm_allowed(perm_allowed), .pfail_event(pfail_event),
        .pfail_count(pfail_b), .button_reset_en(ben_b), .frame_done(done_b), .frame_error(err_b));
    mbcmd_asserts mbcmd_asserts_inst (.clk(clk), .rstn(rstn), .m2s_data(link_a.m2s_data),
        .m2s_valid(link_a.m2s_valid), .s2m_data(link_a.s2m_data), .s2m_valid(link_a.s2m_valid));
    initial forever #2.5 clk = ~clk;
    // ======================================================
    // tasks
    task automatic compare(input logic [19:0] got, input logic [19:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic note(input logic b, input logic ok);
        exp_q.push_back({b, ok, !ok, b ? exp_pb : exp_pa, b ? eben_b : eben_a});
    endtask
    task automatic bump(input int k);
        repeat (k) begin
            pfail_event = 1'b1;
            @(negedge clk);
            pfail_event = 1'b0;
            @(negedge clk);
        end
        exp_pa += 16'(k);
        exp_pb += 16'(k);
    endtask
    task automatic send(input logic btn, input logic [7:0] addr, input logic val);
        req = 1'b1;
        req_button = btn;
        req_addr = addr;
        req_value = val;
        @(negedge clk);
        req = 1'b0;
        repeat (2) @(negedge clk);
        for (int i = 0; i < 40 && busy !== 1'b0; i++)
            @(negedge clk);
        repeat (4) @(negedge clk);
    endtask
    // pos and flip spoil one byte; the checksum is kept right unless it is the one spoilt
    task automatic raw(input logic btn, input logic [7:0] ctl, input logic [7:0] val,
        input int pos, input logic [7:0] flip);
        logic [7:0] f[14];
        int n;
        n = btn ? 14 : 13;
        f = '{8'h68, btn ? 8'h08 : 8'h07, btn ? 8'h08 : 8'h07, 8'h68, ctl, own_addr, 8'h51,
            {7'h0, btn}, 8'hff, btn ? 8'hf9 : 8'h98, btn ? 8'h08 : 8'h07, val, 8'h00, 8'h00};
        if (pos < n - 2)
            f[pos] ^= flip;
        f[n - 2] = 8'h00;
        for (int i = 4; i < n - 2; i++)
            f[n - 2] += f[i];
        f[n - 1] = 8'h16;
        if (pos >= n - 2)
            f[pos] ^= flip;
        for (int i = 0; i < n; i++) begin
            link_b.m2s_data = f[i];
            link_b.m2s_valid = 1'b1;
            @(negedge clk);
        end
        link_b.m2s_valid = 1'b0;
        link_b.m2s_data = ~f[n - 1];
        repeat (4) @(negedge clk);
    endtask
    // ======================================================
    // result watcher and watchdog
    initial begin
        logic [19:0] got;
        forever begin
            @(negedge clk);
            if (rstn && (done_a || err_a || done_b || err_b)) begin
                got[19:17] = (done_b || err_b) ? {1'b1, done_b, err_b} : {1'b0, done_a, err_a};
                @(negedge clk);
                got[16:0] = got[19] ? {pfail_b, ben_b} : {pfail_a, ben_a};
                compare(got, exp_q.size() ? exp_q.pop_front() : 20'hfffff);
                // the master flags the ack one cycle after the meter sends it
                if (!got[19])
                    compare(20'(ack_seen), 20'(got[18]));
            end
        end
    end
    initial begin
        repeat (4000) @(posedge clk);
        n_errors++;
        summarize();
    end
    // ======================================================
    // main sequence
    initial begin
        link_b.m2s_valid = 1'b0;
        link_b.m2s_data = 8'h00;
        own_addr = 8'h20 + {1'b0, 7'($random(seed))};
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        compare({3'h0, pfail_a, ben_a}, {3'h0, 16'h0, 1'b1});
        bump(1 + ($random(seed) & 15));
        exp_pa = 16'h0;
        note(1'b0, 1'b1);
        send(1'b0, own_addr, 1'b0);
        for (int v = 0; v < 4; v++) begin
            {resettable, perm_allowed} = (v < 2) ? 2'b11 : 2'(v - 1);
            eben_a = (v < 2) ? v[0] : eben_a;
            note(1'b0, 1'b1);
            send(1'b1, own_addr, 1'b0 ^ (v == 1));
        end
        {resettable, perm_allowed} = 2'b11;
        note(1'b0, 1'b0);
        send(1'b0, own_addr ^ 8'h01, 1'b0);
        $display("joined ends test done");
        bump(3);
        exp_pb = 16'h0;
        note(1'b1, 1'b1);
        raw(1'b0, 8'h73, 8'h00, 0, 8'h00);
        bump(2);
        note(1'b1, 1'b1);
        raw(1'b0, 8'h73, 8'h00, 0, 8'h00);
        exp_pb = 16'h0;
        note(1'b1, 1'b1);
        raw(1'b0, 8'h53, 8'h00, 0, 8'h00);
        note(1'b1, 1'b1);
        raw(1'b1, 8'h73, 8'h02, 0, 8'h00);
        $display("repeat test done");
        bump(1);
        foreach (bad[j]) begin
            note(1'b1, 1'b0);
            raw(1'b0, 8'h53, 8'h00, int'(bad[j][11:8]), bad[j][7:0]);
        end
        exp_pb = 16'h0;
        note(1'b1, 1'b1);
        raw(1'b0, 8'h53, 8'h00, 0, 8'h00);
        $display("corrupt frame test done");
        compare(20'(exp_q.size()), 20'h0);
        summarize();
    end
endmodule

// [hw/mbcmd_if.sv]
// byte link between bus master and meter
// assumes both ends on one clock; valid strobes for one cycle per byte
`timescale 1ns/1ps
interface mbcmd_if;
    logic [7:0] m2s_data;
    logic m2s_valid;
    logic [7:0] s2m_data;
    logic s2m_valid;
    modport meter(input m2s_data, input m2s_valid, output s2m_data, output s2m_valid);
    modport master(output m2s_data, output m2s_valid, input s2m_data, input s2m_valid);
endinterface

// [hw/mbcmd_master.sv]
// master end: sends a clear or button-permission frame on request
// assumes requests only while busy is low; one byte per cycle
`timescale 1ns/1ps
module mbcmd_master (
    input wire logic clk,
    input wire logic rstn,
    mbcmd_if.master link,
    input wire logic req,
    input wire logic req_button,
    input wire logic [7:0] req_addr,
    input wire logic req_value,
    output logic busy,
    output logic ack_seen
);
    typedef struct packed {
        logic [3:0] idx;
        logic [7:0] sum;
        logic fcb;
        logic button;
        logic [7:0] addr;
        logic value;
        logic busy;
        logic ack;
        logic [7:0] data;
        logic valid;
    } mbcmd_mst_t;
    mbcmd_mst_t s_q, s_d;
    logic [7:0] b;
    logic [3:0] last;

    // ======================================================
    // byte sequencer
    always_comb begin
        s_d = s_q;
        b = 8'h00;
        last = s_q.button ? 4'hd : 4'hc;
        s_d.valid = 1'b0;
        s_d.ack = link.s2m_valid && link.s2m_data == mbcmd_pkg::ACK_BYTE;
        unique case (s_q.idx)
            4'h0, 4'h3: b = mbcmd_pkg::START_BYTE;
            4'h1, 4'h2: b = s_q.button ? mbcmd_pkg::LEN_BUTTON : mbcmd_pkg::LEN_CLEAR;
            4'h4: b = {2'b01, s_q.fcb, 1'b1, mbcmd_pkg::FUNC_SEND};
            4'h5: b = s_q.addr;
            4'h6: b = mbcmd_pkg::CI_SEND;
            4'h7: b = s_q.button ? mbcmd_pkg::DIF_INT8 : mbcmd_pkg::DIF_NONE;
            4'h8: b = mbcmd_pkg::VIF_MAKER;
            4'h9: b = s_q.button ? mbcmd_pkg::VIFE_BUTTON : mbcmd_pkg::VIFE_PFAIL;
            4'ha: b = s_q.button ? mbcmd_pkg::VIFE_BUTTON2 : mbcmd_pkg::VIFE_CLEAR;
            4'hb: b = s_q.button ? {7'h00, s_q.value} : s_q.sum;
            4'hc: b = s_q.button ? s_q.sum : mbcmd_pkg::STOP_BYTE;
            default: b = mbcmd_pkg::STOP_BYTE;
        endcase
        if (!s_q.busy) begin
            if (req) begin
                s_d.busy = 1'b1;
                s_d.idx = mbcmd_pkg::IDX_RESET;
                s_d.sum = mbcmd_pkg::SUM_RESET;
                s_d.button = req_button;
                s_d.addr = req_addr;
                s_d.value = req_value;
                s_d.fcb = ~s_q.fcb;
            end
        end else begin
            s_d.data = b;
            s_d.valid = 1'b1;
            if (s_q.idx >= 4'h4) begin
                s_d.sum = s_q.sum + b;
            end
            s_d.idx = s_q.idx + 4'h1;
            if (s_q.idx == last) begin
                s_d.busy = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.m2s_data = s_q.data;
    assign link.m2s_valid = s_q.valid;
    assign busy = s_q.busy;
    assign ack_seen = s_q.ack;
endmodule

// [hw/mbcmd_meter.sv]
// meter end: decodes clear-counter and button-permission frames
// assumes one byte per valid strobe, bytes arrive from logic on clk
// Behaviour
// - frame opens start, length, length, start
// - length 07 clear, 08 button; copies match
// - control byte 01x1 0011, send user data
// - count bit honoured only when valid bit set
// - master toggles count bit per new transfer
// - direction bit one, top bit zero
// - act only on own primary address
// - control-information byte is 51
// - data information 00 clear, 01 button
// - ff98 07 clears power-fail counter
// - ff is maker-specific, extensions follow
// - fff908 then data byte sets permission
// - permission change only if factory allows
// - checksum over control to data, then 16
`timescale 1ns/1ps
module mbcmd_meter #(
    parameter int PFAIL_W = mbcmd_pkg::PFAIL_WIDTH
) (
    input wire logic clk,
    input wire logic rstn,
    mbcmd_if.meter link,
    input wire logic [7:0] own_addr,
    input wire logic resettable,
    input wire logic perm_allowed,
    input wire logic pfail_event,
    output logic [PFAIL_W-1:0] pfail_count,
    output logic button_reset_en,
    output logic frame_done,
    output logic frame_error
);
    typedef enum logic [1:0] {
        MBCMD_IDLE = 2'b00,
        MBCMD_RECV = 2'b01,
        MBCMD_SKIP = 2'b10
    } mbcmd_st_t;

    typedef struct packed {
        mbcmd_st_t st;
        logic [3:0] idx;
        logic [7:0] len;
        logic [7:0] sum;
        logic [7:0] ctl;
        logic [7:0] arg;
        logic ok;
        logic fcb_known;
        logic fcb_last;
        logic [PFAIL_W-1:0] pfail;
        logic button_en;
        logic [7:0] tx_data;
        logic tx_valid;
        logic done;
        logic err;
    } mbcmd_met_t;
    mbcmd_met_t s_q, s_d;

    // ======================================================
    // field checks
    function automatic logic ctl_ok(input logic [7:0] c);
        ctl_ok = c[3:0] == mbcmd_pkg::FUNC_SEND && c[mbcmd_pkg::CTL_FCV_BIT]
            && c[mbcmd_pkg::CTL_DIR_BIT] && !c[mbcmd_pkg::CTL_ZERO_BIT];
    endfunction

    function automatic logic expect_ok(input logic [3:0] i, input logic btn, input logic [7:0] d);
        unique case (i)
            4'h6: expect_ok = d == mbcmd_pkg::CI_SEND;
            4'h7: expect_ok = d == (btn ? mbcmd_pkg::DIF_INT8 : mbcmd_pkg::DIF_NONE);
            4'h8: expect_ok = d == mbcmd_pkg::VIF_MAKER;
            4'h9: expect_ok = d == (btn ? mbcmd_pkg::VIFE_BUTTON : mbcmd_pkg::VIFE_PFAIL);
            4'ha: expect_ok = d == (btn ? mbcmd_pkg::VIFE_BUTTON2 : mbcmd_pkg::VIFE_CLEAR);
            default: expect_ok = 1'b1;
        endcase
    endfunction

    logic btn;
    logic [3:0] cs_idx;
    logic [7:0] d;
    logic addr_hit;
    logic repeat_frame;

    // ======================================================
    // receive sequencer
    always_comb begin
        s_d = s_q;
        d = link.m2s_data;
        btn = s_q.len == mbcmd_pkg::LEN_BUTTON;
        cs_idx = s_q.len[3:0] + 4'h4;
        addr_hit = own_addr != mbcmd_pkg::ADDR_NONE && own_addr <= mbcmd_pkg::ADDR_MAX;
        repeat_frame = s_q.ctl[mbcmd_pkg::CTL_FCV_BIT] && s_q.fcb_known
            && s_q.fcb_last == s_q.ctl[mbcmd_pkg::CTL_FCB_BIT];
        s_d.tx_valid = 1'b0;
        s_d.done = 1'b0;
        s_d.err = 1'b0;
        if (pfail_event) begin
            s_d.pfail = s_q.pfail + 1'b1;
        end
        if (link.m2s_valid) begin
            unique case (s_q.st)
                MBCMD_IDLE: begin
                    if (d == mbcmd_pkg::START_BYTE) begin
                        s_d.st = MBCMD_RECV;
                        s_d.idx = 4'h1;
                        s_d.sum = mbcmd_pkg::SUM_RESET;
                        s_d.ok = 1'b1;
                    end
                end
                MBCMD_RECV: begin
                    s_d.idx = s_q.idx + 4'h1;
                    if (s_q.idx >= 4'h4 && s_q.idx < cs_idx) begin
                        s_d.sum = s_q.sum + d;
                    end
                    if (s_q.idx == 4'h1) begin
                        s_d.len = d;
                        s_d.ok = d == mbcmd_pkg::LEN_CLEAR || d == mbcmd_pkg::LEN_BUTTON;
                    end else if (s_q.idx == 4'h2) begin
                        s_d.ok = s_q.ok && d == s_q.len;
                    end else if (s_q.idx == 4'h3) begin
                        s_d.ok = s_q.ok && d == mbcmd_pkg::START_BYTE;
                    end else if (s_q.idx == 4'h4) begin
                        s_d.ctl = d;
                        s_d.ok = s_q.ok && ctl_ok(d);
                    end else if (s_q.idx == 4'h5) begin
                        s_d.ok = s_q.ok && addr_hit && d == own_addr;
                    end else if (s_q.idx == 4'hb && btn) begin
                        s_d.arg = d;
                    end else if (s_q.idx == cs_idx) begin
                        s_d.ok = s_q.ok && d == s_q.sum;
                    end else if (s_q.idx == cs_idx + 4'h1) begin
                        // the frame closes here whether good or not
                        s_d.st = MBCMD_IDLE;
                        if (s_q.ok && d == mbcmd_pkg::STOP_BYTE) begin
                            s_d.done = 1'b1;
                            s_d.tx_data = mbcmd_pkg::ACK_BYTE;
                            s_d.tx_valid = 1'b1;
                            s_d.fcb_known = s_q.ctl[mbcmd_pkg::CTL_FCV_BIT];
                            s_d.fcb_last = s_q.ctl[mbcmd_pkg::CTL_FCB_BIT];
                            if (!repeat_frame) begin
                                if (!btn) begin
                                    s_d.pfail = '0;
                                end else if (resettable && perm_allowed
                                             && s_q.arg <= 8'h01) begin
                                    s_d.button_en = s_q.arg[0];
                                end
                            end
                        end else begin
                            s_d.err = 1'b1;
                        end
                    end
                    if (s_q.idx >= 4'h6 && s_q.idx <= 4'ha) begin
                        s_d.ok = s_q.ok && expect_ok(s_q.idx, btn, d);
                    end
                    if (s_q.idx == 4'h2 && !s_d.ok) begin
                        // a length mismatch leaves the real frame size unknown
                        s_d.st = MBCMD_SKIP;
                        s_d.err = 1'b1;
                    end
                end
                MBCMD_SKIP: begin
                    if (d == mbcmd_pkg::STOP_BYTE) begin
                        s_d.st = MBCMD_IDLE;
                    end
                end
                default: s_d.st = MBCMD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.button_en <= mbcmd_pkg::BUTTON_EN_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.s2m_data = s_q.tx_data;
    assign link.s2m_valid = s_q.tx_valid;
    assign pfail_count = s_q.pfail;
    assign button_reset_en = s_q.button_en;
    assign frame_done = s_q.done;
    assign frame_error = s_q.err;
endmodule

// [hw/mbcmd_pkg.sv]
// package for the meter bus maintenance command decoder
// assumes byte-serial transfer with one valid strobe per byte on one clock
package mbcmd_pkg;
    // ======================================================
    // frame bytes
    localparam logic [7:0] START_BYTE = 8'h68;
    localparam logic [7:0] STOP_BYTE = 8'h16;
    localparam logic [7:0] ACK_BYTE = 8'he5;
    localparam logic [7:0] LEN_CLEAR = 8'h07;
    localparam logic [7:0] LEN_BUTTON = 8'h08;
    localparam logic [3:0] FUNC_SEND = 4'h3;
    localparam logic [7:0] CI_SEND = 8'h51;
    localparam logic [7:0] DIF_NONE = 8'h00;
    localparam logic [7:0] DIF_INT8 = 8'h01;
    localparam logic [7:0] VIF_MAKER = 8'hff;
    localparam logic [7:0] VIFE_PFAIL = 8'h98;
    localparam logic [7:0] VIFE_CLEAR = 8'h07;
    localparam logic [7:0] VIFE_BUTTON = 8'hf9;
    localparam logic [7:0] VIFE_BUTTON2 = 8'h08;
    localparam logic [7:0] ADDR_NONE = 8'h00;
    localparam logic [7:0] ADDR_MAX = 8'hfa;
    // ======================================================
    // control byte fields
    localparam int CTL_FCV_BIT = 4;
    localparam int CTL_FCB_BIT = 5;
    localparam int CTL_DIR_BIT = 6;
    localparam int CTL_ZERO_BIT = 7;
    // ======================================================
    // reset values and counts
    localparam logic [3:0] IDX_RESET = 4'h0;
    localparam logic [7:0] SUM_RESET = 8'h00;
    localparam logic BUTTON_EN_RESET = 1'b1;
    localparam int PFAIL_WIDTH = 16;
    localparam int FRAME_MAX = 14;
endpackage
